/* File: sep_bit_engine.sv */
// Two-wire bit engine: synchronises the pins, frames bytes, drives data and ack
module sep_bit_engine
(
  input  wire logic  linkClk,
  input  wire logic  nrst,
  input  wire logic  sclPin,
  input  wire logic  sdaPin,
  output logic       sdaOe,
  sep_link_if.engine lk
);
  localparam logic [3:0] BIT_RXDONE_L = sep_pkg::BIT_RXDONE;
  localparam logic [3:0] BIT_ACK_L    = sep_pkg::BIT_ACK;
  localparam logic [3:0] BIT_LAST_L   = sep_pkg::BIT_LAST;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclPrev;
  logic       sdaPrev;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic       active;
  logic       txByteMode;
  logic       halted;
  logic       sclRise;
  logic       sclFall;
  logic       start;
  logic       stop;

  assign sclRise = sclSync[1] & ~sclPrev;
  assign sclFall = ~sclSync[1] & sclPrev;
  assign start   = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  assign stop    = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

  // Idle bus is high, so the pipeline resets high to avoid a false start
  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
    begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else if (lk.en)
    begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaPin};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end

  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
    begin
      lk.startSeen <= 1'b0;
      lk.stopSeen  <= 1'b0;
      lk.byteRx    <= 1'b0;
      lk.ackRx     <= 1'b0;
      lk.masterAck <= 1'b0;
      lk.rxByte    <= 8'h00;
      shift        <= 8'h00;
      bitCnt       <= 4'h0;
      active       <= 1'b0;
      txByteMode   <= 1'b0;
      halted       <= 1'b0;
      sdaOe        <= 1'b0;
    end
    else if (lk.en)
    begin
      lk.startSeen <= start;
      lk.stopSeen  <= stop;
      lk.byteRx    <= 1'b0;
      lk.ackRx     <= 1'b0;
      if (start)
      begin
        active     <= 1'b1;
        halted     <= 1'b0;
        bitCnt     <= 4'h0;
        txByteMode <= 1'b0;
        sdaOe      <= 1'b0;
      end
      else if (stop)
      begin
        active <= 1'b0;
        sdaOe  <= 1'b0;
      end
      else if (active && sclRise)
      begin
        bitCnt <= bitCnt + 4'h1;
        if (bitCnt < BIT_ACK_L)
          shift <= {shift[6:0], sdaSync[1]};
        if (bitCnt == BIT_RXDONE_L && !txByteMode)
        begin
          lk.byteRx <= 1'b1;
          lk.rxByte <= {shift[6:0], sdaSync[1]};
        end
        // A refused byte from the master ends our transmission
        if (bitCnt == BIT_ACK_L && txByteMode)
        begin
          lk.ackRx     <= 1'b1;
          lk.masterAck <= ~sdaSync[1];
          if (sdaSync[1])
            halted <= 1'b1;
        end
      end
      else if (active && sclFall)
      begin
        if (bitCnt == BIT_ACK_L)
          sdaOe <= ~txByteMode & lk.ackDrive & ~halted;
        else if (bitCnt == BIT_LAST_L)
        begin
          bitCnt     <= 4'h0;
          txByteMode <= lk.txMode;
          sdaOe      <= lk.txMode & ~halted & ~lk.txByte[7];
        end
        else
          sdaOe <= txByteMode & ~halted & ~lk.txByte[3'(4'h7 - bitCnt)];
      end
    end

endmodule : sep_bit_engine

/* File: sep_i2c_master.sv */
// Bus master model driving clock and data of the two-wire link
module sep_i2c_master
(
  input  wire logic clk,
  input  wire logic sdaWire,
  output logic      sclPin,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 12;
  initial
  begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end
  task pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause
  // Data moves a quarter period after the fall, so no false start is seen
  task xfer(input logic b, output logic r);
    pause(QTR);
    sdaLow <= ~b;
    pause(QTR);
    sclPin <= 1'b1;
    pause(2 * QTR);
    r = sdaWire;
    sclPin <= 1'b0;
  endtask : xfer
  // Start, repeated start or stop; a stop leaves the clock high and still
  task cond(input logic first, input logic last);
    pause(QTR);
    sdaLow <= first;
    pause(QTR);
    sclPin <= 1'b1;
    pause(2 * QTR);
    sdaLow <= last;
    pause(2 * QTR);
    sclPin <= ~last;
  endtask : cond
  task start();
    cond(1'b0, 1'b1);
  endtask : start
  task stop();
    cond(1'b1, 1'b0);
  endtask : stop
  task sendByte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(v[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask : sendByte
  task readByte(input logic mAck, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer(1'b1, r);
      v[i] = r;
    end
    xfer(~mAck, r);
  endtask : readByte
endmodule : sep_i2c_master

/* File: sep_link_if.sv */
// Byte-level carrier between the bit engine and the command controller
interface sep_link_if;
  logic       en;
  logic       startSeen;
  logic       stopSeen;
  logic       byteRx;
  logic       ackRx;
  logic       masterAck;
  logic [7:0] rxByte;
  logic [7:0] txByte;
  logic       ackDrive;
  logic       txMode;

  modport engine (input en, ackDrive, txMode, txByte,
                  output startSeen, stopSeen, byteRx, ackRx, masterAck, rxByte);
  modport ctrl (output en, ackDrive, txMode, txByte,
                input startSeen, stopSeen, byteRx, ackRx, masterAck, rxByte);
endinterface : sep_link_if

/* File: sep_pkg.sv */
// Constants and types for the SPD EEPROM protection and read logic
package sep_pkg;
  localparam logic [3:0] ARRAY_CODE   = 4'hA;
  localparam logic [3:0] PROT_CODE    = 4'h6;
  localparam logic [2:0] SEL_BLK0     = 3'h1;
  localparam logic [2:0] SEL_BLK1     = 3'h4;
  localparam logic [2:0] SEL_BLK2     = 3'h5;
  localparam logic [2:0] SEL_BLK3     = 3'h0;
  localparam logic [2:0] SEL_CLEAR    = 3'h3;
  localparam logic [2:0] SEL_BANK0    = 3'h6;
  localparam logic [2:0] SEL_BANK1    = 3'h7;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [3:0] PROT_RESET   = 4'h0;
  localparam logic [1:0] MAX_TRAIL    = 2'h2;
  localparam logic [3:0] BIT_RXDONE   = 4'h7;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_LAST     = 4'h9;
  localparam int         PAGE_BYTES   = 16;
  localparam int         BANK_BYTES   = 256;
  localparam int         CLK_PERIOD_NS  = 5;
  localparam int         WRITE_CYCLE_NS = 5000000;
  localparam int         WRITE_CYCLES   = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ADDR   = 8'h02,
    ST_WORD   = 8'h04,
    ST_WDATA  = 8'h08,
    ST_RDATA  = 8'h10,
    ST_STATUS = 8'h20,
    ST_TRAIL  = 8'h40,
    ST_IGNORE = 8'h80
  } sep_state_t;

  typedef enum logic [1:0] {
    PD_NONE              = 2'h0,
    PD_SET_BLOCK_PROTECT = 2'h1,
    PD_CLEAR_ALL_PROTECT = 2'h2,
    PD_WRITE             = 2'h3
  } sep_pend_t;
endpackage : sep_pkg

/* File: sep_top.sv */
// SPD EEPROM slave: block protection, bank select, array reads and writes
// Overview of operation
// - Clear command under high voltage unprotects everything
// - Code 0110 ignores the slave-address pins
// - Block select bits map to four blocks
// - Clear is code 0110, bits 011, write
// - Set and clear need high voltage; status never
// - Status read: NAK protected, ACK unprotected
// - Undefined 0110 address bytes are ignored
// - Up to two trailing bytes acknowledged, ignored
// - Protect and clear execute only on STOP
// - Bank select always acknowledged, immediate, no cycle
// - Status answered in ninth bit, then 0xFF
// - Direction bit one starts a read
// - Pointer holds next address after last access
// - Word address then restart gives random read
// - Master ack gets next byte, pointer increments
// - Standby once idle and internal cycle done
// - Array access uses code 1010
// - Bank status: ACK bank 0, NAK bank 1
// - Writes to a protected block refused
module sep_top #(
  parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clkEn,
  input  wire logic       linkClk,
  input  wire logic       sclPin,
  input  wire logic       sdaPin,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [2:0] addrPins,
  input  wire logic       highVoltageLevel,
  output logic            standbyLowPower,
  output logic            writeBusy,
  output logic [3:0]      protectedBlocks,
  output logic            currentBank
);
  sep_link_if lk ();

  sep_bit_engine u_engine (
    .linkClk (linkClk),
    .nrst    (nrst),
    .sclPin  (sclPin),
    .sdaPin  (sdaPin),
    .sdaOe   (sdaOe),
    .lk      (lk)
  );

  sep_pkg::sep_state_t st;
  sep_pkg::sep_pend_t  pend;
  logic [1:0]  enSync;
  logic [1:0]  hvSync;
  logic [2:0]  pinSync0;
  logic [2:0]  pinSync1;
  logic [1:0]  ackSync;
  logic        reqTgl;
  logic        busy;
  logic [7:0]  ptr;
  logic        bank;
  logic [3:0]  protect;
  logic [1:0]  trailCnt;
  logic        linkIdle;
  logic [7:0]  mem [2 * sep_pkg::BANK_BYTES];
  logic [7:0]  pageBuf [sep_pkg::PAGE_BYTES];
  logic [15:0] pageHit;
  logic [3:0]  code;
  logic [2:0]  sel;
  logic        rw;
  logic [1:0]  selBlk;
  logic        selIsBlk;
  logic        statBit;
  logic        adrByte;
  logic        protCmd;
  logic        arrCmd;
  logic        isArrWr;
  logic        isArrRd;
  logic        isSet;
  logic        isStat;
  logic        isClr;
  logic        isBank;
  logic        isBankRd;
  logic        wordByte;
  logic        dataOk;
  logic        dataBad;
  logic        seqAck;
  logic        commit;
  logic        ackTgl;
  logic [1:0]  pendBlk;

  assign lk.en    = enSync[1];
  assign busy     = reqTgl ^ ackSync[1];
  assign code     = lk.rxByte[7:4];
  assign sel      = lk.rxByte[3:1];
  assign rw       = lk.rxByte[0];
  assign adrByte  = lk.byteRx && st == sep_pkg::ST_ADDR;
  assign protCmd  = code == sep_pkg::PROT_CODE;
  assign arrCmd   = code == sep_pkg::ARRAY_CODE && sel == pinSync1;
  assign isArrWr  = adrByte && arrCmd && !rw && !busy;
  assign isArrRd  = adrByte && arrCmd && rw && !busy;
  assign isSet    = adrByte && protCmd && selIsBlk && !rw;
  assign isStat   = adrByte && protCmd && selIsBlk && rw;
  assign isClr    = adrByte && protCmd && sel == sep_pkg::SEL_CLEAR && !rw;
  assign isBank   = adrByte && protCmd && sel[2:1] == sep_pkg::SEL_BANK0[2:1] && !rw;
  assign isBankRd = adrByte && protCmd && sel == sep_pkg::SEL_BANK0 && rw;
  assign wordByte = lk.byteRx && st == sep_pkg::ST_WORD;
  assign dataOk   = lk.byteRx && st == sep_pkg::ST_WDATA && !protect[{bank, ptr[7]}];
  assign dataBad  = lk.byteRx && st == sep_pkg::ST_WDATA && protect[{bank, ptr[7]}];
  assign seqAck   = lk.ackRx && lk.masterAck && st == sep_pkg::ST_RDATA;
  assign commit   = lk.stopSeen && pend != sep_pkg::PD_NONE;
  assign statBit  = protect[selBlk];

  always_comb
  begin
    selBlk   = 2'h0;
    selIsBlk = 1'b1;
    unique case (sel)
      sep_pkg::SEL_BLK0: selBlk = 2'h0;
      sep_pkg::SEL_BLK1: selBlk = 2'h1;
      sep_pkg::SEL_BLK2: selBlk = 2'h2;
      sep_pkg::SEL_BLK3: selBlk = 2'h3;
      default:           selIsBlk = 1'b0;
    endcase
  end

  // Enable crosses in unqualified so that a frozen domain can wake up
  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
      enSync <= 2'h0;
    else
      enSync <= {enSync[0], clkEn};

  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
    begin
      hvSync   <= 2'h0;
      pinSync0 <= 3'h0;
      pinSync1 <= 3'h0;
      ackSync  <= 2'h0;
      sdaOut   <= 1'b0;
    end
    else if (lk.en)
    begin
      hvSync   <= {hvSync[0], highVoltageLevel};
      pinSync0 <= addrPins;
      pinSync1 <= pinSync0;
      ackSync  <= {ackSync[0], ackTgl};
      sdaOut   <= 1'b0;
    end

  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
    begin
      st          <= sep_pkg::ST_IDLE;
      pend        <= sep_pkg::PD_NONE;
      trailCnt    <= 2'h0;
      lk.ackDrive <= 1'b0;
      lk.txMode   <= 1'b0;
      lk.txByte   <= sep_pkg::IDLE_BYTE;
      linkIdle    <= 1'b1;
    end
    else if (lk.en)
    begin
      linkIdle <= st == sep_pkg::ST_IDLE;
      if (lk.startSeen)
      begin
        // A restart abandons an unfinished write but keeps the pointer
        st        <= sep_pkg::ST_ADDR;
        pend      <= sep_pkg::PD_NONE;
        lk.txMode <= 1'b0;
      end
      else if (lk.stopSeen)
      begin
        st        <= sep_pkg::ST_IDLE;
        pend      <= sep_pkg::PD_NONE;
        lk.txMode <= 1'b0;
      end
      else if (lk.byteRx)
      begin
        lk.ackDrive <= 1'b0;
        trailCnt    <= 2'h0;
        unique case (st)
          sep_pkg::ST_ADDR:
            if (isArrWr)
            begin
              lk.ackDrive <= 1'b1;
              st          <= sep_pkg::ST_WORD;
            end
            else if (isArrRd)
            begin
              lk.ackDrive <= 1'b1;
              lk.txMode   <= 1'b1;
              lk.txByte   <= mem[{bank, ptr}];
              st          <= sep_pkg::ST_RDATA;
            end
            else if (isSet && hvSync[1] && !busy)
            begin
              lk.ackDrive <= !statBit;
              pend        <= statBit ? sep_pkg::PD_NONE : sep_pkg::PD_SET_BLOCK_PROTECT;
              st          <= statBit ? sep_pkg::ST_IGNORE : sep_pkg::ST_TRAIL;
            end
            else if ((isClr && hvSync[1] && !busy) || isBank)
            begin
              lk.ackDrive <= 1'b1;
              pend        <= isClr ? sep_pkg::PD_CLEAR_ALL_PROTECT : sep_pkg::PD_NONE;
              st          <= sep_pkg::ST_TRAIL;
            end
            else if (isStat || isBankRd)
            begin
              // Answer lives in the ack bit; any data clocked out is all ones
              lk.ackDrive <= isStat ? !statBit : !bank;
              lk.txMode   <= isStat ? !statBit : !bank;
              lk.txByte   <= sep_pkg::IDLE_BYTE;
              st          <= sep_pkg::ST_STATUS;
            end
            else
              st <= sep_pkg::ST_IGNORE;
          sep_pkg::ST_WORD:
          begin
            lk.ackDrive <= 1'b1;
            st          <= sep_pkg::ST_WDATA;
          end
          sep_pkg::ST_WDATA:
          begin
            lk.ackDrive <= dataOk;
            if (dataOk)
              pend <= sep_pkg::PD_WRITE;
          end
          sep_pkg::ST_TRAIL:
          begin
            lk.ackDrive <= trailCnt < sep_pkg::MAX_TRAIL;
            trailCnt    <= (trailCnt < sep_pkg::MAX_TRAIL) ? trailCnt + 2'h1 : trailCnt;
          end
          sep_pkg::ST_IDLE, sep_pkg::ST_RDATA, sep_pkg::ST_STATUS, sep_pkg::ST_IGNORE:
            lk.ackDrive <= 1'b0;
          default:
            st <= sep_pkg::ST_IGNORE;
        endcase
      end
      else if (seqAck)
        lk.txByte <= mem[{bank, ptr}];
    end

  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
      ptr <= sep_pkg::PTR_RESET;
    else if (lk.en)
    begin
      if (wordByte)
        ptr <= lk.rxByte;
      else if (dataOk)
        ptr <= {ptr[7:4], ptr[3:0] + 4'h1};
      else if (isArrRd || seqAck)
        ptr <= ptr + 8'h01;
    end

  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
    begin
      protect <= sep_pkg::PROT_RESET;
      bank    <= 1'b0;
      pageHit <= 16'h0000;
      reqTgl  <= 1'b0;
    end
    else if (lk.en)
    begin
      if (isBank)
        bank <= sel[0];
      if (lk.startSeen)
        pageHit <= 16'h0000;
      else if (dataOk)
        pageHit[ptr[3:0]] <= 1'b1;
      if (commit)
      begin
        reqTgl <= ~reqTgl;
        if (pend == sep_pkg::PD_CLEAR_ALL_PROTECT)
          protect <= sep_pkg::PROT_RESET;
        else if (pend == sep_pkg::PD_SET_BLOCK_PROTECT)
          protect[pendBlk] <= 1'b1;
      end
    end

  always_ff @(posedge linkClk or negedge nrst)
    if (!nrst)
      pendBlk <= 2'h0;
    else if (lk.en && isSet)
      pendBlk <= selBlk;

  // Array cells are not reset; the page lands only when the STOP commits it
  always_ff @(posedge linkClk)
    if (lk.en)
    begin
      if (dataOk)
        pageBuf[ptr[3:0]] <= lk.rxByte;
      if (commit && pend == sep_pkg::PD_WRITE)
        for (int i = 0; i < sep_pkg::PAGE_BYTES; i++)
          if (pageHit[i])
            mem[{bank, ptr[7:4], 4'(i)}] <= pageBuf[i];
    end

  logic [1:0]  reqSync;
  logic        busyClk;
  logic [19:0] cycCnt;
  logic [1:0]  idleSync;
  logic [3:0]  protSync0;
  logic [3:0]  protSync1;
  logic [1:0]  bankSync;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      reqSync <= 2'h0;
      ackTgl  <= 1'b0;
      busyClk <= 1'b0;
      cycCnt  <= 20'h00000;
    end
    else if (clkEn)
    begin
      reqSync <= {reqSync[0], reqTgl};
      if (!busyClk && reqSync[1] != ackTgl)
      begin
        busyClk <= 1'b1;
        cycCnt  <= 20'h00000;
      end
      else if (busyClk && cycCnt == 20'(WRITE_CYCLES - 1))
      begin
        busyClk <= 1'b0;
        ackTgl  <= reqSync[1];
      end
      else if (busyClk)
        cycCnt <= cycCnt + 20'h00001;
    end

  // Protection and bank bits are quasi-static, so plain double sampling will do
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      idleSync        <= 2'h0;
      protSync0       <= 4'h0;
      protSync1       <= 4'h0;
      bankSync        <= 2'h0;
      standbyLowPower <= 1'b0;
      writeBusy       <= 1'b0;
      protectedBlocks <= 4'h0;
      currentBank     <= 1'b0;
    end
    else if (clkEn)
    begin
      idleSync        <= {idleSync[0], linkIdle};
      protSync0       <= protect;
      protSync1       <= protSync0;
      bankSync        <= {bankSync[0], bank};
      standbyLowPower <= idleSync[1] && !busyClk && reqSync[1] == ackTgl;
      writeBusy       <= busyClk;
      protectedBlocks <= protSync1;
      currentBank     <= bankSync[1];
    end

  sequence s_bank1_cmd;
    lk.en && adrByte && protCmd && sel == sep_pkg::SEL_BANK1 && !rw;
  endsequence

  sequence s_busy_clk;
    clkEn && busyClk;
  endsequence

  a_clear_exec: assert property (@(posedge linkClk) disable iff (!nrst)
    lk.en && lk.stopSeen && pend == sep_pkg::PD_CLEAR_ALL_PROTECT |=> protect == 4'h0)
    else $error("clear command did not unprotect all blocks");
  a_bank_select: assert property (@(posedge linkClk) disable iff (!nrst)
    s_bank1_cmd |=> lk.ackDrive && bank && pend == sep_pkg::PD_NONE)
    else $error("bank select not acknowledged or not applied");
  a_hv_needed: assert property (@(posedge linkClk) disable iff (!nrst)
    lk.en && adrByte && protCmd && !rw && (selIsBlk || sel == sep_pkg::SEL_CLEAR)
      && !hvSync[1] |=> !lk.ackDrive && st == sep_pkg::ST_IGNORE)
    else $error("protection write taken without high voltage");
  a_status_ack: assert property (@(posedge linkClk) disable iff (!nrst)
    lk.en && isStat |=> lk.ackDrive == !$past(statBit))
    else $error("status ack does not match protection");
  a_trail_ack: assert property (@(posedge linkClk) disable iff (!nrst)
    lk.en && lk.byteRx && st == sep_pkg::ST_TRAIL
      |=> lk.ackDrive == ($past(trailCnt) < sep_pkg::MAX_TRAIL))
    else $error("trailing byte ack count wrong");
  a_stop_only: assert property (@(posedge linkClk) disable iff (!nrst)
    !(lk.en && lk.stopSeen) |=> $stable(protect))
    else $error("protection changed without a stop");
  a_status_ones: assert property (@(posedge linkClk) disable iff (!nrst)
    st == sep_pkg::ST_STATUS |-> lk.txByte == sep_pkg::IDLE_BYTE)
    else $error("status read data is not all ones");
  a_seq_pointer: assert property (@(posedge linkClk) disable iff (!nrst)
    lk.en && seqAck |=> ptr == $past(ptr) + 8'h01 ##1 !lk.ackRx)
    else $error("sequential read pointer did not advance");
  a_prot_data: assert property (@(posedge linkClk) disable iff (!nrst)
    lk.en && dataBad |=> !lk.ackDrive && pend != sep_pkg::PD_WRITE)
    else $error("data into protected block was accepted");
  a_standby_busy: assert property (@(posedge clk) disable iff (!nrst)
    s_busy_clk |=> !standbyLowPower)
    else $error("standby shown during internal cycle");
endmodule : sep_top

/* File: tb_spd_eeprom_protect_and_read.sv */
// Self-checking bench for the SPD EEPROM protection and read slave
`define CHK(what, exp, got) \
  begin \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
      badCount++; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_spd_eeprom_protect_and_read;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 40;
  // Pins sit at 010, so array traffic uses A4 and A5
  localparam logic [7:0] ARR = 8'hA4;
  localparam logic [2:0] SEL [4] = '{sep_pkg::SEL_BLK0, sep_pkg::SEL_BLK1,
                                     sep_pkg::SEL_BLK2, sep_pkg::SEL_BLK3};
  logic       clk = 1'b0;
  logic       linkClk = 1'b0;
  logic       nrst, hv, sclPin, sdaLow, sdaWire, sdaOut, sdaOe;
  logic       standby, writeBusy, currentBank, ack, seen;
  logic [2:0] addrPins;
  logic [3:0] protectedBlocks;
  logic [7:0] d;
  int         nTests = 0;
  int         badCount = 0;

  // Open-drain wire with pull-up
  assign sdaWire = ~sdaLow & (sdaOe ? sdaOut : 1'b1);
  always #2.5 clk = ~clk;
  initial
  begin
    #1.1;
    forever #7.5 linkClk = ~linkClk;
  end

  sep_top #(.WRITE_CYCLES(WCYC)) dut_u
  (
    .clk(clk), .nrst(nrst), .clkEn(1'b1), .linkClk(linkClk),
    .sclPin(sclPin), .sdaPin(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrPins(addrPins), .highVoltageLevel(hv), .standbyLowPower(standby),
    .writeBusy(writeBusy), .protectedBlocks(protectedBlocks), .currentBank(currentBank)
  );
  sep_i2c_master bm
  (
    .clk(clk), .sdaWire(sdaWire), .sclPin(sclPin), .sdaLow(sdaLow)
  );

  task endSim();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : endSim
  function logic [7:0] pc(input logic [2:0] s, input logic r);
    return {sep_pkg::PROT_CODE, s, r};
  endfunction : pc
  task frame(input logic [7:0] b);
    bm.start();
    bm.sendByte(b, ack);
  endtask : frame
  // Bounded watch for an internal cycle; it must also be over at the end
  task waitWrite();
    seen = 1'b0;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clk);
      seen = seen | writeBusy;
    end
    if (writeBusy !== 1'b0)
    begin
      badCount++;
      $display("MISMATCH busy expected 0 seen %b", writeBusy);
      endSim();
    end
  endtask : waitWrite

  task tSet();
    logic [3:0] mask;
    mask = 4'h0;
    for (int n = 0; n < 4; n++)
    begin
      hv <= 1'b0;
      frame(pc(SEL[n], 1'b1));
      `CHK("stat", 1'b1, ack)
      bm.readByte(1'b0, d);
      `CHK("stat data", 8'hFF, d)
      bm.stop();
      hv <= 1'b1;
      frame(pc(SEL[n], 1'b0));
      `CHK("set", 1'b1, ack)
      for (int k = 0; k < n; k++)
      begin
        bm.sendByte(8'h3C, ack);
        `CHK("trail", 1'(k < 2), ack)
      end
      `CHK("standby", 1'b0, standby)
      `CHK("early", 1'b0, protectedBlocks[n])
      bm.stop();
      waitWrite();
      `CHK("cycle", 1'b1, seen)
      mask[n] = 1'b1;
      `CHK("blocks", mask, protectedBlocks)
    end
    $display("set test done");
  endtask : tSet

  task tRefuse();
    hv <= 1'b0;
    frame(pc(sep_pkg::SEL_CLEAR, 1'b0));
    `CHK("no hv", 1'b0, ack)
    bm.stop();
    waitWrite();
    `CHK("no hv cycle", 1'b0, seen)
    for (int n = 0; n < 4; n++)
    begin
      frame(pc(SEL[n], 1'b1));
      `CHK("stat", 1'b0, ack)
      bm.stop();
    end
    hv <= 1'b1;
    frame(pc(sep_pkg::SEL_BLK1, 1'b0));
    `CHK("reset", 1'b0, ack)
    bm.sendByte(8'h00, ack);
    `CHK("reset trail", 1'b0, ack)
    bm.stop();
    frame(8'h64);
    `CHK("undefined", 1'b0, ack)
    bm.stop();
    frame(8'hA0);
    `CHK("pins", 1'b0, ack)
    bm.stop();
    frame(ARR);
    bm.sendByte(8'h90, ack);
    `CHK("word", 1'b1, ack)
    bm.sendByte(8'h55, ack);
    `CHK("data", 1'b0, ack)
    bm.stop();
    waitWrite();
    `CHK("cycle", 1'b0, seen)
    $display("refuse test done");
  endtask : tRefuse

  task tClear();
    frame(pc(sep_pkg::SEL_CLEAR, 1'b0));
    `CHK("clear", 1'b1, ack)
    bm.stop();
    waitWrite();
    `CHK("cleared", 4'h0, protectedBlocks)
    hv <= 1'b0;
    bm.pause(8);
    `CHK("standby", 1'b1, standby)
    $display("clear test done");
  endtask : tClear

  task tBank();
    frame(pc(sep_pkg::SEL_BANK1, 1'b0));
    `CHK("bank1", 1'b1, ack)
    bm.pause(24);
    `CHK("bank", 1'b1, currentBank)
    frame(pc(sep_pkg::SEL_BANK0, 1'b1));
    `CHK("bank stat", 1'b0, ack)
    frame(pc(sep_pkg::SEL_BANK0, 1'b0));
    bm.pause(24);
    `CHK("bank", 1'b0, currentBank)
    frame(pc(sep_pkg::SEL_BANK0, 1'b1));
    `CHK("bank stat", 1'b1, ack)
    bm.stop();
    $display("bank test done");
  endtask : tBank

  task tRead();
    frame(ARR);
    bm.sendByte(8'h10, ack);
    bm.sendByte(8'h5A, ack);
    bm.sendByte(8'hC3, ack);
    bm.sendByte(8'h3C, ack);
    bm.stop();
    waitWrite();
    `CHK("write", 1'b1, seen)
    frame(ARR);
    bm.sendByte(8'h10, ack);
    frame(ARR | 8'h01);
    `CHK("read", 1'b1, ack)
    bm.readByte(1'b1, d);
    `CHK("random", 8'h5A, d)
    bm.readByte(1'b0, d);
    `CHK("next", 8'hC3, d)
    bm.stop();
    frame(ARR | 8'h01);
    bm.readByte(1'b0, d);
    `CHK("current", 8'h3C, d)
    bm.stop();
    $display("read test done");
  endtask : tRead

  initial
  begin
    nrst = 1'b0;
    hv = 1'b0;
    addrPins = 3'h2;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    bm.pause(20);
    `CHK("idle", 1'b1, standby)
    tSet();
    tRefuse();
    tClear();
    tBank();
    tRead();
    endSim();
  end
endmodule : tb_spd_eeprom_protect_and_read
